/* File: core/sar_adc_register_control.sv */
// Contract
// - Result split: high byte, low nibble
// - Result read-only, unknown until conversion
// - Straight binary result code
// - Bit 7 enables converter, resets 0
// - Start bit, self-clears at end
// - End bit low during, set at end
// - Channel select decode, battery channel 01110
// - Clock source: high or low oscillator
// - Global gate connects selected channel
// - Divider 16, 8, 1, 2
// - Internal or external high reference
// - Reference level decode
// - Port-1 pure analog bits
// - Port-2 pure analog bits 5:0
// - Converter interrupt enable bit
// - Converter interrupt request flag
// - Global interrupt enable gates request
// - Completion sets flags, loads result
// - Service entry clears request flag
// - Conversion lasts 64 converter clocks
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module sar_adc_register_control #(
    parameter int result_bits = sar_adc_pkg::result_width,
    parameter int conv_cycles = sar_adc_pkg::conversion_clock_cycles
) (
    // System
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    // Oscillator ticks
    input  wire logic                   high_osc_tick,
    input  wire logic                   low_osc_tick,
    // Analog core
    input  wire logic [result_bits-1:0] sample_code,
    output logic                        analog_enable,
    output logic                        sample_active,
    output logic      [13:0]            channel_connect,
    output logic                        battery_detect_channel,
    output logic                        external_reference_pin,
    output logic      [2:0]             internal_reference_level,
    output logic      [7:0]             port1_pure_analog,
    output logic      [5:0]             port2_pure_analog,
    // Interrupt controller
    input  wire logic                   irq_service_enter,
    output logic                        converter_irq
);

    // ****************************************
    // Registers
    // ****************************************
    logic                   converter_on;
    logic                   conversion_start;
    logic                   end_of_conversion;
    logic [4:0]             channel_select;
    logic                   conv_clock_source;
    logic                   global_channel_gate;
    logic [1:0]             conv_clock_divider;
    logic                   external_reference_on;
    logic [2:0]             internal_reference_level_reg;
    logic [7:0]             port1_analog_config;
    logic [5:0]             port2_analog_config;
    logic                   converter_irq_enable;
    logic                   converter_irq_flag;
    logic                   global_irq_enable;
    logic [result_bits-1:0] result;
    logic [6:0]             tick_count;
    logic                   done;

    // ****************************************
    // Bus address phase capture
    // ****************************************
    logic       wr_pending;
    logic [7:0] wr_addr;
    logic       rd_pending;
    logic [7:0] rd_addr;
    logic       access;

    assign access = hsel && hready && htrans[1];

    // ****************************************
    // Register index decode
    // ****************************************
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        return (a[31:10] == 22'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'hff;
    endfunction

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
        end else if (hready) begin
            wr_pending <= access && hwrite;
            wr_addr    <= reg_index(haddr);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_pending <= 1'b0;
            rd_addr    <= 8'h00;
        end else if (hready) begin
            rd_pending <= access && !hwrite;
            rd_addr    <= reg_index(haddr);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    function automatic logic is_write(input logic [7:0] a);
        return wr_pending && (wr_addr == a);
    endfunction

    logic [7:0] wbyte;
    assign wbyte = hwdata[7:0];

    // ****************************************
    // Conversion timing
    // ****************************************
    conv_clock_if cc ();

    assign cc.source_tick = conv_clock_source ? low_osc_tick : high_osc_tick;
    assign cc.divider     = conv_clock_divider;
    assign cc.run         = converter_on && conversion_start;

    conv_clock_divider u_div (
        .clock (clock),
        .rst_b (rst_b),
        .cc    (cc)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_count <= 7'h00;
        end else if (!cc.run) begin
            tick_count <= 7'h00;
        end else if (cc.tick) begin
            tick_count <= tick_count + 7'h01;
        end
    end

    assign done = cc.run && cc.tick && (tick_count == 7'(conv_cycles - 1));

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            converter_on <= 1'b0;
        end else if (is_write(sar_adc_pkg::converter_control_addr)) begin
            converter_on <= wbyte[sar_adc_pkg::converter_on_bit];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            channel_select <= 5'h00;
        end else if (is_write(sar_adc_pkg::converter_control_addr)) begin
            channel_select <= wbyte[4:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conversion_start <= 1'b0;
        end else if (done) begin
            conversion_start <= 1'b0;
        end else if (is_write(sar_adc_pkg::converter_control_addr)
                     && wbyte[sar_adc_pkg::conversion_start_bit]) begin
            conversion_start <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            end_of_conversion <= 1'b0;
        end else if (done) begin
            end_of_conversion <= 1'b1;
        end else if (is_write(sar_adc_pkg::converter_control_addr)) begin
            if (wbyte[sar_adc_pkg::conversion_start_bit]) begin
                end_of_conversion <= 1'b0;
            end else begin
                end_of_conversion <= wbyte[sar_adc_pkg::end_of_conversion_bit];
            end
        end
    end

    // ****************************************
    // Result buffer
    // ****************************************
    always_ff @(posedge clock) begin
        if (done) begin
            result <= sample_code;
        end
    end

    // ****************************************
    // Clock select register
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            conv_clock_source   <= 1'b0;
            global_channel_gate <= 1'b0;
            conv_clock_divider  <= sar_adc_pkg::divider_by_16;
        end else if (is_write(sar_adc_pkg::clock_select_result_low_addr)) begin
            conv_clock_source   <= wbyte[sar_adc_pkg::conv_clock_source_bit];
            global_channel_gate <= wbyte[sar_adc_pkg::global_channel_gate_bit];
            conv_clock_divider  <= wbyte[sar_adc_pkg::conv_clock_divider_lsb +: 2];
        end
    end

    // ****************************************
    // Reference and port configuration
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            external_reference_on        <= 1'b0;
            internal_reference_level_reg <= 3'h0;
        end else if (is_write(sar_adc_pkg::reference_select_addr)) begin
            external_reference_on        <= wbyte[sar_adc_pkg::external_reference_on_bit];
            internal_reference_level_reg <= wbyte[2:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            port1_analog_config <= sar_adc_pkg::config_reset;
        end else if (is_write(sar_adc_pkg::port1_analog_config_addr)) begin
            port1_analog_config <= wbyte;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            port2_analog_config <= 6'h00;
        end else if (is_write(sar_adc_pkg::port2_analog_config_addr)) begin
            port2_analog_config <= wbyte[5:0];
        end
    end

    // ****************************************
    // Interrupt bits
    // ****************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            converter_irq_enable <= 1'b0;
        end else if (is_write(sar_adc_pkg::interrupt_enable_two_addr)) begin
            converter_irq_enable <= wbyte[sar_adc_pkg::converter_irq_bit];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_enable <= 1'b0;
        end else if (is_write(sar_adc_pkg::interrupt_enable_zero_addr)) begin
            global_irq_enable <= wbyte[sar_adc_pkg::global_irq_enable_bit];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            converter_irq_flag <= 1'b0;
        end else if (done) begin
            converter_irq_flag <= 1'b1;
        end else if (irq_service_enter) begin
            converter_irq_flag <= 1'b0;
        end else if (is_write(sar_adc_pkg::interrupt_request_two_addr)) begin
            converter_irq_flag <= wbyte[sar_adc_pkg::converter_irq_bit];
        end
    end

    assign converter_irq = converter_irq_flag && converter_irq_enable && global_irq_enable;

    // ****************************************
    // Analog side outputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 14; g++) begin : g_chan
            if (g == 13) begin : g_rsvd
                assign channel_connect[g] = 1'b0;
            end else begin : g_used
                assign channel_connect[g] = global_channel_gate
                    && (channel_select == 5'(g));
            end
        end
    endgenerate

    assign battery_detect_channel   = global_channel_gate
        && (channel_select == sar_adc_pkg::channel_battery);
    assign analog_enable            = converter_on;
    assign sample_active            = cc.run;
    assign external_reference_pin   = external_reference_on;
    assign internal_reference_level = internal_reference_level_reg;
    assign port1_pure_analog        = port1_analog_config;
    assign port2_pure_analog        = port2_analog_config;

    // ****************************************
    // Read data
    // ****************************************
    logic [7:0] read_byte;

    always_comb begin
        case (rd_addr)
            sar_adc_pkg::converter_control_addr:
                read_byte = {converter_on, conversion_start, end_of_conversion, channel_select};
            sar_adc_pkg::result_high_addr:
                read_byte = result[11:4];
            sar_adc_pkg::clock_select_result_low_addr:
                read_byte = {conv_clock_source, global_channel_gate, conv_clock_divider,
                             result[3:0]};
            sar_adc_pkg::reference_select_addr:
                read_byte = {external_reference_on, 4'h0, internal_reference_level_reg};
            sar_adc_pkg::port1_analog_config_addr:
                read_byte = port1_analog_config;
            sar_adc_pkg::port2_analog_config_addr:
                read_byte = {2'h0, port2_analog_config};
            sar_adc_pkg::interrupt_enable_zero_addr:
                read_byte = {global_irq_enable, 7'h00};
            sar_adc_pkg::interrupt_enable_two_addr:
                read_byte = {7'h00, converter_irq_enable};
            sar_adc_pkg::interrupt_request_two_addr:
                read_byte = {7'h00, converter_irq_flag};
            default:
                read_byte = 8'h00;
        endcase
    end

    assign hrdata = rd_pending ? {24'h000000, read_byte} : 32'h00000000;

endmodule

/* File: core/sar_adc_pkg.sv */
package sar_adc_pkg;

    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [7:0] interrupt_enable_two_addr    = 8'h9a;
    localparam logic [7:0] port1_analog_config_addr     = 8'h9f;
    localparam logic [7:0] interrupt_enable_zero_addr   = 8'ha8;
    localparam logic [7:0] interrupt_request_two_addr   = 8'hbf;
    localparam logic [7:0] converter_control_addr       = 8'hd2;
    localparam logic [7:0] result_high_addr             = 8'hd3;
    localparam logic [7:0] clock_select_result_low_addr = 8'hd4;
    localparam logic [7:0] reference_select_addr        = 8'hd5;
    localparam logic [7:0] port2_analog_config_addr     = 8'hd6;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int converter_on_bit          = 7;
    localparam int conversion_start_bit      = 6;
    localparam int end_of_conversion_bit     = 5;
    localparam int conv_clock_source_bit     = 7;
    localparam int global_channel_gate_bit   = 6;
    localparam int conv_clock_divider_lsb    = 4;
    localparam int external_reference_on_bit = 7;
    localparam int global_irq_enable_bit     = 7;
    localparam int converter_irq_bit         = 0;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [7:0] config_reset      = 8'h00;
    localparam logic [4:0] channel_last_pin  = 5'h0c;
    localparam logic [4:0] channel_battery   = 5'h0e;
    localparam logic [2:0] ref_level_last    = 3'h6;
    localparam logic [1:0] divider_by_16     = 2'h0;
    localparam logic [1:0] divider_by_8      = 2'h1;
    localparam logic [1:0] divider_by_1      = 2'h2;
    localparam logic [1:0] divider_by_2      = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int conversion_clock_cycles = 64;
    localparam int result_width            = 12;

endpackage

/* File: core/conv_clock_if.sv */
`timescale 1ns/1ps
interface conv_clock_if;
    logic       source_tick;
    logic [1:0] divider;
    logic       run;
    logic       tick;

    modport control (output source_tick, output divider, output run, input tick);
    modport divider_side (input source_tick, input divider, input run, output tick);
endinterface

/* File: core/conv_clock_divider.sv */
`timescale 1ns/1ps
module conv_clock_divider (
    // System
    input wire logic              clock,
    input wire logic              rst_b,
    // Control
    conv_clock_if.divider_side    cc
);

    // ****************************************
    // Prescaler of the selected source
    // ****************************************
    logic [3:0] count;
    logic [3:0] limit;

    always_comb begin
        case (cc.divider)
            sar_adc_pkg::divider_by_16: limit = 4'hf;
            sar_adc_pkg::divider_by_8:  limit = 4'h7;
            sar_adc_pkg::divider_by_1:  limit = 4'h0;
            sar_adc_pkg::divider_by_2:  limit = 4'h1;
            default:                    limit = 4'hf;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= 4'h0;
        end else if (!cc.run) begin
            count <= 4'h0;
        end else if (cc.source_tick) begin
            if (count >= limit) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end

    assign cc.tick = cc.run && cc.source_tick && (count >= limit);

endmodule

/* File: tb/sar_adc_register_control_asserts.sv */
`timescale 1ns/1ps
module sar_adc_register_control_asserts #(
    parameter int result_bits = 12,
    parameter int conv_cycles = 64
) (
    // System
    input wire logic        clock,
    input wire logic        rst_b,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hresp,
    // Converter
    input wire logic        analog_enable,
    input wire logic        sample_active,
    input wire logic [13:0] channel_connect,
    input wire logic        external_reference_pin,
    input wire logic [2:0]  internal_reference_level,
    input wire logic [7:0]  port1_pure_analog,
    input wire logic [5:0]  port2_pure_analog,
    // Interrupt
    input wire logic        irq_service_enter,
    input wire logic        converter_irq
);
    // ****************************************
    // Bus tracking
    // ****************************************
    logic       wr_pend;
    logic [7:0] wr_addr;
    int         run_cnt;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[9:2];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_cnt <= 0;
        end else begin
            run_cnt <= sample_active ? run_cnt + 1 : 0;
        end
    end

    sequence s_write(logic [7:0] addr);
        wr_pend && (wr_addr == addr);
    endsequence

    sequence s_busy_span;
        sample_active [*8];
    endsequence

    // ****************************************
    // Checks
    // ****************************************
    AST_RESET_QUIET:
        assert property (!$past(rst_b) |-> !analog_enable && !sample_active && !converter_irq
                         && port1_pure_analog == 8'h00 && port2_pure_analog == 6'h00)
        else $error("outputs not quiet after reset");
    AST_START_RUNS:
        assert property ((s_write(8'hd2) ##0 (hwdata[7:6] == 2'b11)) |=> s_busy_span)
        else $error("start write did not run a conversion");
    AST_ENABLE_WRITE:
        assert property (s_write(8'hd2) |=> analog_enable == $past(hwdata[7]))
        else $error("converter enable does not follow write");
    AST_MIN_LENGTH:
        assert property ($fell(sample_active) && analog_enable |-> run_cnt >= conv_cycles)
        else $error("conversion ended too early");
    AST_CHANNEL_ONEHOT:
        assert property ($onehot0(channel_connect) && !channel_connect[13])
        else $error("channel connect not one-hot");
    AST_GATE_OFF:
        assert property ((s_write(8'hd4) ##0 !hwdata[6]) |=> channel_connect == 14'h0000)
        else $error("channel connected with gate off");
    AST_PORT1_WRITE:
        assert property (s_write(8'h9f) |=> port1_pure_analog == $past(hwdata[7:0]))
        else $error("port1 config not applied");
    AST_PORT2_WRITE:
        assert property (s_write(8'hd6) |=> port2_pure_analog == $past(hwdata[5:0]))
        else $error("port2 config not applied");
    AST_REF_WRITE:
        assert property (s_write(8'hd5) |=> external_reference_pin == $past(hwdata[7])
                         && internal_reference_level == $past(hwdata[2:0]))
        else $error("reference select not applied");
    AST_IRQ_CLEAR:
        assert property (irq_service_enter && !sample_active |=> !converter_irq)
        else $error("request not cleared by service entry");
    AST_BUS_OKAY:
        assert property (!hresp)
        else $error("slave gave an error response");
endmodule

bind sar_adc_register_control sar_adc_register_control_asserts #(
    .result_bits(result_bits), .conv_cycles(conv_cycles)
) i_asserts (
    .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .analog_enable,
    .sample_active, .channel_connect, .external_reference_pin, .internal_reference_level,
    .port1_pure_analog, .port2_pure_analog, .irq_service_enter, .converter_irq, .hresp
);

/* File: tb/analog_core_model.sv */
`timescale 1ns/1ps
module analog_core_model (
    // System
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Converter side
    input  wire logic        sample_active,
    input  wire logic [11:0] level,
    output logic             high_osc_tick,
    output logic             low_osc_tick,
    output logic      [11:0] sample_code
);
    // ****************************************
    // Oscillators and code
    // ****************************************
    logic [1:0]  low_div;
    logic [11:0] noise;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            low_div       <= 2'h0;
            high_osc_tick <= 1'b0;
            low_osc_tick  <= 1'b0;
            noise         <= 12'h000;
        end else begin
            low_div       <= (low_div == 2'h2) ? 2'h0 : low_div + 2'h1;
            high_osc_tick <= 1'b1;
            low_osc_tick  <= (low_div == 2'h2);
            noise         <= noise + 12'h5a7;
        end
    end

    // Code only holds while sampling
    assign sample_code = sample_active ? level : ~level ^ noise;
endmodule

/* File: tb/sar_adc_register_control_tb.sv */
`timescale 1ns/1ps
`define CHECK(name, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end
module sar_adc_register_control_tb;
    logic        clock;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        high_osc_tick;
    logic        low_osc_tick;
    logic [11:0] sample_code;
    logic [11:0] level;
    logic        sample_active;
    logic [13:0] channel_connect;
    logic        battery_detect_channel;
    logic        external_reference_pin;
    logic [2:0]  internal_reference_level;
    logic [7:0]  port1_pure_analog;
    logic [5:0]  port2_pure_analog;
    logic        irq_service_enter;
    logic        converter_irq;
    logic [7:0]  rd;
    int          num_errors;
    int          compares;
    int          run_len;
    logic [7:0]  reg_addr [9] = '{8'hd2, 8'hd4, 8'hd5, 8'h9f, 8'hd6, 8'ha8, 8'h9a, 8'hbf, 8'h10};
    logic [7:0]  reg_mask [9] = '{8'hff, 8'hf0, 8'h87, 8'hff, 8'h3f, 8'h80, 8'h01, 8'h01, 8'hff};
    logic [1:0]  cv_div [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    logic        cv_src [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int          cv_n [5] = '{16, 8, 1, 2, 3};
    logic [11:0] cv_code [5] = '{12'h000, 12'hfff, 12'ha5c, 12'h3c1, 12'h7e8};
    logic [7:0]  cv_ch [5] = '{8'h01, 8'h05, 8'h0c, 8'h0e, 8'h00};

    sar_adc_register_control i_dut (
        .clock, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp(), .high_osc_tick, .low_osc_tick, .sample_code,
        .analog_enable(), .sample_active, .channel_connect, .external_reference_pin,
        .internal_reference_level, .port1_pure_analog, .port2_pure_analog, .irq_service_enter,
        .converter_irq, .battery_detect_channel
    );

    analog_core_model i_model (
        .clock, .rst_b, .sample_active, .level, .high_osc_tick, .low_osc_tick, .sample_code
    );

    // ****************************************
    // Clock, watchdog and bus tasks
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        test_done();
    end

    always @(posedge clock) if (sample_active === 1'b1) run_len <= run_len + 1;

    task automatic test_done();
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, addr, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wdata};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata[7:0];
        if (wr) @(posedge clock);
    endtask

    task automatic check_reg(input logic [7:0] addr, mask, exp);
        access(1'b0, addr, 8'h00);
        `CHECK($sformatf("register %h", addr), exp & mask, rd & mask)
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
        hwdata = 32'h0; irq_service_enter = 1'b0; level = 12'h000; rst_b = 1'b0;
        num_errors = 0; compares = 0; run_len = 0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (reg_addr[i]) check_reg(reg_addr[i], reg_mask[i], 8'h00);
        access(1'b1, 8'h9f, 8'ha5);
        access(1'b1, 8'hd6, 8'h2a);
        check_reg(8'h9f, 8'hff, 8'ha5);
        check_reg(8'hd6, 8'h3f, 8'h2a);
        for (int l = 0; l < 7; l++) begin
            access(1'b1, 8'hd5, 8'h80 | 8'(l));
            `CHECK("internal_reference_level", 3'(l), internal_reference_level)
            `CHECK("external_reference_pin", 1'b1, external_reference_pin)
        end
        access(1'b1, 8'hd4, 8'h40);
        for (int c = 14; c >= 0; c--) if (c != 13) begin
            access(1'b1, 8'hd2, 8'(c));
            `CHECK("channel_connect", (c < 13) ? 14'(1 << c) : 14'h0000, channel_connect)
            `CHECK("battery_detect_channel", c == 14, battery_detect_channel)
        end
        access(1'b1, 8'hd4, 8'h00);
        `CHECK("channel_connect", 14'h0000, channel_connect)
        access(1'b1, 8'ha8, 8'h80);
        access(1'b1, 8'h9a, 8'h01);
        access(1'b1, 8'hd5, 8'h04);
        for (int i = 0; i < 5; i++) begin
            level <= cv_code[i];
            access(1'b1, 8'hd4, {cv_src[i], 1'b1, cv_div[i], 4'h0});
            run_len = 0;
            access(1'b1, 8'hd2, 8'hc0 | cv_ch[i]);
            check_reg(8'hd2, 8'hff, 8'hc0 | cv_ch[i]);
            if (i > 0) check_reg(8'hd3, 8'hff, cv_code[i-1][11:4]);
            while (sample_active === 1'b1) @(posedge clock);
            @(posedge clock);
            `CHECK("conversion_cycles", 64, (run_len + cv_n[i] - 1) / cv_n[i])
            check_reg(8'hd2, 8'hff, 8'ha0 | cv_ch[i]);
            check_reg(8'hd3, 8'hff, cv_code[i][11:4]);
            check_reg(8'hd4, 8'hff, {cv_src[i], 1'b1, cv_div[i], cv_code[i][3:0]});
            check_reg(8'hbf, 8'h01, 8'h01);
            `CHECK("converter_irq", 1'b1, converter_irq)
            if (i == 0) begin
                access(1'b1, 8'hd3, 8'hff);
                access(1'b1, 8'hd4, {cv_src[i], 1'b1, cv_div[i], 4'hf});
                check_reg(8'hd3, 8'hff, 8'h00);
                check_reg(8'hd4, 8'h0f, 8'h00);
                access(1'b1, 8'ha8, 8'h00);
                `CHECK("converter_irq", 1'b0, converter_irq)
                access(1'b1, 8'ha8, 8'h80);
                access(1'b1, 8'h9a, 8'h00);
                `CHECK("converter_irq", 1'b0, converter_irq)
                access(1'b1, 8'h9a, 8'h01);
            end
            irq_service_enter <= 1'b1;
            @(posedge clock);
            irq_service_enter <= 1'b0;
            @(posedge clock);
            `CHECK("converter_irq", 1'b0, converter_irq)
            check_reg(8'hbf, 8'h01, 8'h00);
        end
        test_done();
    end
endmodule
